/* File: gdfs_pkg.sv */
package gdfs_pkg;

    // ****************************************************************
    // Clock and timing
    // ****************************************************************
    localparam int CLK_PERIOD_NS     = 50;
    localparam int DEGLITCH_HW_NS    = 4000;
    localparam int RETRY_NS          = 4000000;
    localparam int GATE_TIMEOUT_NS   = 4000;
    localparam int SLEEP_DELAY_NS    = 100000;
    localparam int WAKE_DELAY_NS     = 1000000;
    localparam int RESET_WINDOW_NS   = 20000;

    // Least times round up to whole cycles, never below one cycle.
    function automatic int min_cycles(input int t_ns);
        int c;
        c = (t_ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
        return (c < 1) ? 1 : c;
    endfunction

    localparam int DEGLITCH_HW_CYC   = min_cycles(DEGLITCH_HW_NS);
    localparam int RETRY_CYC         = min_cycles(RETRY_NS);
    localparam int GATE_TIMEOUT_CYC  = min_cycles(GATE_TIMEOUT_NS);
    localparam int SLEEP_DELAY_CYC   = min_cycles(SLEEP_DELAY_NS);
    localparam int WAKE_DELAY_CYC    = min_cycles(WAKE_DELAY_NS);
    localparam int RESET_WINDOW_CYC  = min_cycles(RESET_WINDOW_NS);

    // Deglitch choices selected by deglitch_sel, in ns.
    localparam int DEGLITCH_SEL0_NS  = 2000;
    localparam int DEGLITCH_SEL1_NS  = 4000;
    localparam int DEGLITCH_SEL2_NS  = 6000;
    localparam int DEGLITCH_SEL3_NS  = 8000;

    // ****************************************************************
    // Register map (byte addresses)
    // ****************************************************************
    localparam logic [7:0] ADDR_CTRL   = 8'h00;
    localparam logic [7:0] ADDR_CFG    = 8'h04;
    localparam logic [7:0] ADDR_STATUS = 8'h08;
    localparam logic [7:0] ADDR_FLAGS  = 8'h0C;

    // Control register fields.
    localparam int CTRL_CLEAR_BIT      = 0;
    localparam int CTRL_GDF_DIS_BIT    = 1;
    localparam int CTRL_THERMAL_WARNING_REPORT_BIT    = 2;
    localparam int CTRL_SEN_DIS_BIT    = 3;

    // Config register fields.
    localparam int CFG_MODE_LSB        = 0;
    localparam int CFG_DEG_LSB         = 2;
    localparam int CFG_LVL_LSB         = 4;

    // Flags register fields.
    localparam int FLAGS_VDS_LSB       = 0;
    localparam int FLAGS_VGS_LSB       = 6;

    // ****************************************************************
    // Encodings and reset values
    // ****************************************************************
    localparam logic [1:0] MODE_LATCHED = 2'h0;
    localparam logic [1:0] MODE_RETRY   = 2'h1;
    localparam logic [1:0] MODE_REPORT  = 2'h2;
    localparam logic [1:0] MODE_OFF     = 2'h3;
    localparam logic [1:0] LVL_1V       = 2'h3;
    localparam logic [1:0] DEG_4US      = 2'h1;

    localparam int NUM_FETS = 6;

    typedef struct packed {
        logic [1:0] shunt_threshold_sel;
        logic [1:0] deglitch_sel;
        logic [1:0] overcurrent_mode;
    } gdfs_cfg_s;

    typedef struct packed {
        logic shunt_ocp_disable;
        logic thermal_warning_report;
        logic gate_fault_disable;
    } gdfs_ctrl_s;

    localparam gdfs_cfg_s  CFG_RESET  = '{LVL_1V, DEG_4US, MODE_LATCHED};
    localparam gdfs_ctrl_s CTRL_RESET = '{1'b0, 1'b0, 1'b0};

    typedef struct packed {
        logic psel;
        logic penable;
        logic pwrite;
        logic [7:0] paddr;
        logic [31:0] pwdata;
    } gdfs_apb_req_s;

endpackage

/* File: gdfs_supervisor.sv */
`timescale 1ns/100ps
module gdfs_supervisor #(
    parameter bit HW_IF            = 1'b0,
    parameter int RETRY_CYCLES     = gdfs_pkg::RETRY_CYC,
    parameter int WAKE_CYCLES      = gdfs_pkg::WAKE_DELAY_CYC,
    parameter int SLEEP_CYCLES     = gdfs_pkg::SLEEP_DELAY_CYC,
    parameter int RST_WIN_CYCLES   = gdfs_pkg::RESET_WINDOW_CYC,
    parameter int GATE_TO_CYCLES   = gdfs_pkg::GATE_TIMEOUT_CYC
) (
    input  wire logic                          ref_clk,
    input  wire logic                          reset,
    input  wire logic                          psel,
    input  wire logic                          penable,
    input  wire logic                          pwrite,
    input  wire logic [7:0]                    paddr,
    input  wire logic [31:0]                   pwdata,
    output logic [31:0]                        prdata,
    output logic                               pready,
    output logic                               pslverr,
    input  wire logic                          enable,
    input  wire logic                          supply_undervoltage,
    input  wire logic                          shunt_sense_input,
    input  wire logic [gdfs_pkg::NUM_FETS-1:0] vds_over,
    input  wire logic [gdfs_pkg::NUM_FETS-1:0] gate_cmd,
    input  wire logic [gdfs_pkg::NUM_FETS-1:0] gate_at_level,
    input  wire logic                          temp_warn,
    input  wire logic                          temp_shutdown,
    output logic                               fault_out_n,
    output logic                               gates_enable,
    output logic                               charge_pump_en,
    output logic                               regulators_en,
    output logic                               serial_en,
    output logic [1:0]                         shunt_threshold_sel
);

    localparam int NF = gdfs_pkg::NUM_FETS;
    localparam int RW = $clog2(RETRY_CYCLES + 1);
    localparam int EW = $clog2(SLEEP_CYCLES + WAKE_CYCLES + 1);
    localparam int GW = $clog2(GATE_TO_CYCLES + 1);
    localparam int DW = $clog2(gdfs_pkg::min_cycles(gdfs_pkg::DEGLITCH_SEL3_NS) + 1);

    // ****************************************************************
    // State
    // ****************************************************************
    gdfs_pkg::gdfs_cfg_s     cfg_reg;
    gdfs_pkg::gdfs_ctrl_s    ctrl_reg;
    gdfs_pkg::gdfs_apb_req_s apb;
    logic                    clear_cmd_reg;
    logic                    asleep_reg;
    logic                    enable_d_reg;
    logic [EW-1:0]           low_cnt_reg;
    logic [EW-1:0]           wake_cnt_reg;
    logic                    en_pulse_clear;
    logic                    clear_any;
    logic [DW-1:0]           deg_cnt_reg;
    logic                    shunt_over;
    logic                    shunt_overcurrent_reg;
    logic                    shunt_stop_reg;
    logic                    retry_active_reg;
    logic [RW-1:0]           retry_cnt_reg;
    logic                    retry_done;
    logic                    drain_source_overcurrent_reg;
    logic [NF-1:0]           vds_fet_reg;
    logic                    gate_drive_fault_reg;
    logic [NF-1:0]           gate_voltage_flags_reg;
    logic [NF-1:0]           gate_cmd_d_reg;
    logic [GW-1:0]           gate_cnt_reg [NF];
    logic [NF-1:0]           gate_miss;
    logic                    thermal_warning_reg;
    logic                    thermal_shutdown_flag_reg;
    logic                    fault_summary;
    logic                    operating;
    logic                    powering;
    logic [1:0]              mode;
    logic [DW-1:0]           deg_limit;
    logic                    cfg_wipe;
    logic                    fault_out_n_next;

    assign apb = '{psel, penable, pwrite, paddr, pwdata};

    function automatic logic [DW-1:0] deglitch_cycles(input logic [1:0] sel);
        unique case (sel)
            2'h0: return DW'(gdfs_pkg::min_cycles(gdfs_pkg::DEGLITCH_SEL0_NS));
            2'h1: return DW'(gdfs_pkg::min_cycles(gdfs_pkg::DEGLITCH_SEL1_NS));
            2'h2: return DW'(gdfs_pkg::min_cycles(gdfs_pkg::DEGLITCH_SEL2_NS));
            2'h3: return DW'(gdfs_pkg::min_cycles(gdfs_pkg::DEGLITCH_SEL3_NS));
        endcase
    endfunction

    // ****************************************************************
    // Effective configuration
    // ****************************************************************
    always_comb begin
        if (HW_IF) begin
            mode      = gdfs_pkg::MODE_RETRY;
            deg_limit = DW'(gdfs_pkg::DEGLITCH_HW_CYC);
        end else begin
            mode      = cfg_reg.overcurrent_mode;
            deg_limit = deglitch_cycles(cfg_reg.deglitch_sel);
        end
    end

    always_ff @(posedge ref_clk) begin
        shunt_threshold_sel <= HW_IF ? gdfs_pkg::LVL_1V : cfg_reg.shunt_threshold_sel;
    end

    // ****************************************************************
    // APB slave
    // ****************************************************************
    logic setup_ph;
    logic access_wr;
    logic addr_ok;

    // The serial port is dead while asleep, so any access then errors out.
    assign addr_ok   = serial_en && (apb.paddr == gdfs_pkg::ADDR_CTRL ||
                       apb.paddr == gdfs_pkg::ADDR_CFG || apb.paddr == gdfs_pkg::ADDR_STATUS ||
                       apb.paddr == gdfs_pkg::ADDR_FLAGS);
    assign setup_ph  = apb.psel && !apb.penable;
    assign access_wr = apb.psel && apb.penable && apb.pwrite && addr_ok;
    assign pready    = 1'b1;
    assign pslverr   = apb.psel && apb.penable && !addr_ok;

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            prdata <= 32'h0000_0000;
        end else if (setup_ph) begin
            prdata <= 32'h0000_0000;
            if (serial_en) begin
                unique case (apb.paddr)
                    gdfs_pkg::ADDR_CTRL:   prdata <= {28'h000_0000, ctrl_reg, 1'b0};
                    gdfs_pkg::ADDR_CFG:    prdata <= {26'h000_0000, cfg_reg};
                    gdfs_pkg::ADDR_STATUS: prdata <= {24'h00_0000, operating,
                        supply_undervoltage, thermal_shutdown_flag_reg, thermal_warning_reg,
                        gate_drive_fault_reg, shunt_overcurrent_reg,
                        drain_source_overcurrent_reg, fault_summary};
                    gdfs_pkg::ADDR_FLAGS:  prdata <= {20'h0_0000, gate_voltage_flags_reg,
                                                      vds_fet_reg};
                    default:               prdata <= 32'h0000_0000;
                endcase
            end
        end
    end

    // Configuration is wiped on sleep and undervoltage as well as on reset.
    assign cfg_wipe = reset || asleep_reg || supply_undervoltage;

    always_ff @(posedge ref_clk) begin
        if (cfg_wipe) begin
            cfg_reg  <= gdfs_pkg::CFG_RESET;
            ctrl_reg <= gdfs_pkg::CTRL_RESET;
        end else if (access_wr) begin
            if (apb.paddr == gdfs_pkg::ADDR_CFG)
                cfg_reg <= apb.pwdata[gdfs_pkg::CFG_LVL_LSB+1:gdfs_pkg::CFG_MODE_LSB];
            if (apb.paddr == gdfs_pkg::ADDR_CTRL)
                ctrl_reg <= apb.pwdata[gdfs_pkg::CTRL_SEN_DIS_BIT:gdfs_pkg::CTRL_GDF_DIS_BIT];
        end
    end

    // Command bit lives for one cycle only and reads back as zero.
    always_ff @(posedge ref_clk) begin
        if (reset)
            clear_cmd_reg <= 1'b0;
        else
            clear_cmd_reg <= access_wr && apb.paddr == gdfs_pkg::ADDR_CTRL &&
                             apb.pwdata[gdfs_pkg::CTRL_CLEAR_BIT];
    end

    // ****************************************************************
    // Enable pin: sleep, wake and reset pulse
    // ****************************************************************
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            enable_d_reg <= 1'b0;
            low_cnt_reg  <= '0;
            asleep_reg   <= 1'b1;
            wake_cnt_reg <= '0;
        end else begin
            enable_d_reg <= enable;
            if (enable) begin
                low_cnt_reg <= '0;
                if (asleep_reg) begin
                    asleep_reg   <= 1'b0;
                    wake_cnt_reg <= EW'(WAKE_CYCLES);
                end else if (wake_cnt_reg != '0) begin
                    wake_cnt_reg <= wake_cnt_reg - 1'b1;
                end
            end else begin
                wake_cnt_reg <= '0;
                if (!asleep_reg) begin
                    if (low_cnt_reg == EW'(SLEEP_CYCLES - 1))
                        asleep_reg <= 1'b1;
                    low_cnt_reg <= low_cnt_reg + 1'b1;
                end
            end
        end
    end

    // A short low phase is a fault reset; a longer one starts the shutdown.
    assign en_pulse_clear = enable && !enable_d_reg && !asleep_reg &&
                            low_cnt_reg != '0 && low_cnt_reg < EW'(RST_WIN_CYCLES);
    assign powering  = (!enable && low_cnt_reg >= EW'(RST_WIN_CYCLES) && !asleep_reg) ||
                       (wake_cnt_reg != '0);
    assign operating = enable && !supply_undervoltage && !asleep_reg &&
                       wake_cnt_reg == '0 && !powering;
    assign clear_any = clear_cmd_reg || en_pulse_clear;

    // ****************************************************************
    // Shunt overcurrent
    // ****************************************************************
    always_ff @(posedge ref_clk) begin
        if (reset || !shunt_sense_input)
            deg_cnt_reg <= '0;
        else if (deg_cnt_reg != deg_limit)
            deg_cnt_reg <= deg_cnt_reg + 1'b1;
    end

    assign shunt_over = shunt_sense_input && deg_cnt_reg == deg_limit && operating;
    assign retry_done = retry_active_reg && retry_cnt_reg == RW'(RETRY_CYCLES - 1);

    always_ff @(posedge ref_clk) begin
        if (reset || asleep_reg) begin
            shunt_overcurrent_reg <= 1'b0;
            shunt_stop_reg        <= 1'b0;
            retry_active_reg      <= 1'b0;
            retry_cnt_reg         <= '0;
        end else begin
            if (retry_active_reg)
                retry_cnt_reg <= retry_cnt_reg + 1'b1;
            if (retry_done) begin
                retry_active_reg      <= 1'b0;
                shunt_overcurrent_reg <= 1'b0;
                retry_cnt_reg         <= '0;
            end else if (clear_any && !shunt_sense_input && !retry_active_reg) begin
                shunt_overcurrent_reg <= 1'b0;
                shunt_stop_reg        <= 1'b0;
            end
            // A new event wins over a clear in the same cycle.
            if (shunt_over && !(HW_IF ? 1'b0 : ctrl_reg.shunt_ocp_disable) &&
                mode != gdfs_pkg::MODE_OFF && !retry_active_reg) begin
                shunt_overcurrent_reg <= 1'b1;
                if (mode == gdfs_pkg::MODE_LATCHED)
                    shunt_stop_reg <= 1'b1;
                if (mode == gdfs_pkg::MODE_RETRY) begin
                    retry_active_reg <= 1'b1;
                    retry_cnt_reg    <= '0;
                end
            end
        end
    end

    // ****************************************************************
    // Drain-source overcurrent (reported, never stops the drivers)
    // ****************************************************************
    always_ff @(posedge ref_clk) begin
        if (reset || asleep_reg) begin
            drain_source_overcurrent_reg <= 1'b0;
            vds_fet_reg                  <= '0;
        end else begin
            if (clear_any && vds_over == '0) begin
                drain_source_overcurrent_reg <= 1'b0;
                vds_fet_reg                  <= '0;
            end
            if (vds_over != '0 && operating && mode != gdfs_pkg::MODE_OFF) begin
                drain_source_overcurrent_reg <= 1'b1;
                vds_fet_reg                  <= (clear_any ? '0 : vds_fet_reg) | vds_over;
            end
        end
    end

    // ****************************************************************
    // Gate drive monitor
    // ****************************************************************
    logic gdf_enabled;
    assign gdf_enabled = HW_IF || !ctrl_reg.gate_fault_disable;

    always_ff @(posedge ref_clk) begin
        if (reset || !gates_enable) begin
            gate_cmd_d_reg <= gate_cmd;
            gate_miss      <= '0;
            for (int i = 0; i < NF; i++)
                gate_cnt_reg[i] <= '0;
        end else begin
            gate_cmd_d_reg <= gate_cmd;
            for (int i = 0; i < NF; i++) begin
                gate_miss[i] <= 1'b0;
                if (gate_cmd[i] != gate_cmd_d_reg[i]) begin
                    gate_cnt_reg[i] <= GW'(GATE_TO_CYCLES);
                end else if (gate_cnt_reg[i] != '0) begin
                    if (gate_at_level[i] == gate_cmd[i])
                        gate_cnt_reg[i] <= '0;
                    else if (gate_cnt_reg[i] == GW'(1)) begin
                        gate_cnt_reg[i] <= '0;
                        gate_miss[i]    <= 1'b1;
                    end else
                        gate_cnt_reg[i] <= gate_cnt_reg[i] - 1'b1;
                end
            end
        end
    end

    always_ff @(posedge ref_clk) begin
        if (reset || asleep_reg) begin
            gate_drive_fault_reg   <= 1'b0;
            gate_voltage_flags_reg <= '0;
        end else begin
            if (clear_any && gate_at_level == gate_cmd) begin
                gate_drive_fault_reg   <= 1'b0;
                gate_voltage_flags_reg <= '0;
            end
            if (gate_miss != '0 && gdf_enabled) begin
                gate_drive_fault_reg   <= 1'b1;
                gate_voltage_flags_reg <= (clear_any ? '0 : gate_voltage_flags_reg) |
                                          gate_miss;
            end
        end
    end

    // ****************************************************************
    // Thermal
    // ****************************************************************
    always_ff @(posedge ref_clk) begin
        if (reset) begin
            thermal_warning_reg       <= 1'b0;
            thermal_shutdown_flag_reg <= 1'b0;
        end else begin
            thermal_warning_reg <= temp_warn;
            if (clear_any && !temp_shutdown)
                thermal_shutdown_flag_reg <= 1'b0;
            if (temp_shutdown)
                thermal_shutdown_flag_reg <= 1'b1;
        end
    end

    // ****************************************************************
    // Outputs
    // ****************************************************************
    assign fault_summary = shunt_overcurrent_reg || drain_source_overcurrent_reg ||
                           gate_drive_fault_reg || thermal_shutdown_flag_reg;

    // Thermal shutdown pulls the pin only while hot; its flag stays for software.
    assign fault_out_n_next = !(shunt_overcurrent_reg || drain_source_overcurrent_reg ||
                                gate_drive_fault_reg || temp_shutdown || powering ||
                                supply_undervoltage ||
                                (thermal_warning_reg && ctrl_reg.thermal_warning_report));

    always_ff @(posedge ref_clk) begin
        if (reset) begin
            fault_out_n    <= 1'b1;
            gates_enable   <= 1'b0;
            charge_pump_en <= 1'b0;
            regulators_en  <= 1'b0;
            serial_en      <= 1'b0;
        end else begin
            fault_out_n    <= fault_out_n_next;
            // Report-only events leave the drivers alone.
            gates_enable   <= operating && !shunt_stop_reg && !retry_active_reg &&
                              !gate_drive_fault_reg && !temp_shutdown;
            charge_pump_en <= enable && !asleep_reg && !supply_undervoltage &&
                              !temp_shutdown;
            regulators_en  <= enable && !asleep_reg;
            serial_en      <= enable && !asleep_reg && !supply_undervoltage;
        end
    end

endmodule // gdfs_supervisor

/* File: gdfs_monitor.sv */
`timescale 1ns/100ps
module gdfs_monitor #(parameter int SLEEP_CYCLES = 40) (
    input wire logic ref_clk,
    input wire logic reset,
    input wire logic psel,
    input wire logic penable,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic serial_en,
    input wire logic enable,
    input wire logic temp_shutdown,
    input wire logic fault_out_n,
    input wire logic gates_enable,
    input wire logic charge_pump_en
);
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (reset);
    int low;
    always_ff @(posedge ref_clk) low <= (reset || enable) ? 0 : low + 1;
    ready_now_a: assert property (psel && penable |-> pready) else $error("late ready");
    asleep_refuse_a: assert property (psel && penable && !serial_en |-> pslverr) else $error("no refusal");
    tsd_off_a: assert property (temp_shutdown |-> ##[1:3] !gates_enable && !charge_pump_en) else $error("tsd drive on");
    tsd_fault_a: assert property (temp_shutdown [*3] |=> !fault_out_n) else $error("tsd no fault");
    sleep_off_a: assert property (low > SLEEP_CYCLES + 2 |-> !serial_en && !charge_pump_en) else $error("not asleep");
    wake_cause_a: assert property ($rose(serial_en) |-> $past(enable)) else $error("woke without enable");
    gates_op_a: assert property (gates_enable |-> serial_en) else $error("gates while off");
    reset_quiet_a: assert property (disable iff (1'b0) reset |=> fault_out_n && !gates_enable) else $error("reset state");
endmodule // gdfs_monitor
bind gdfs_supervisor gdfs_monitor #(.SLEEP_CYCLES(SLEEP_CYCLES)) gdfs_monitor_inst (.ref_clk, .reset,
    .psel, .penable, .pready, .pslverr, .serial_en, .enable, .temp_shutdown, .fault_out_n,
    .gates_enable, .charge_pump_en);

/* File: gdfs_ctrl_model.sv */
`timescale 1ns/100ps
module gdfs_ctrl_model #(parameter int WAKE = 40, parameter int PW = 4) (
    input wire logic ref_clk,
    input wire logic go,
    input wire logic pulse,
    output logic     enable = 1'b0,
    output logic     ready = 1'b0
);
    int low = 0;
    int cnt = 0;
    // The low phase stays far inside the reset window, so no shutdown starts.
    always @(posedge ref_clk) low <= (pulse && low == 0) ? PW : (low > 0 ? low - 1 : 0);
    always @(posedge ref_clk) enable <= go && low == 0 && !pulse;
    always @(posedge ref_clk) cnt <= enable ? (cnt < WAKE ? cnt + 1 : cnt) : 0;
    always @(posedge ref_clk) ready <= enable && cnt >= WAKE;
endmodule // gdfs_ctrl_model

/* File: tb.sv */
`timescale 1ns/100ps
module tb;
    localparam logic [7:0] CT = gdfs_pkg::ADDR_CTRL, CF = gdfs_pkg::ADDR_CFG;
    localparam logic [7:0] ST = gdfs_pkg::ADDR_STATUS;
    logic ref_clk = 1'b0, reset = 1'b1, go = 1'b0, pulse = 1'b0, shunt = 1'b0, tw = 1'b0;
    logic ts = 1'b0, uv = 1'b0, serr, enable, ready, pready, pslverr;
    logic fault_out_n, gates_enable, cp_en, reg_en, ser_en;
    logic [5:0] vds = 6'h00, gc = 6'h00, gl = 6'h00;
    logic [31:0] prdata, q;
    gdfs_pkg::gdfs_apb_req_s req = '0;
    int errors = 0, tests_run = 0, cyc = 0;
    // Per row: mode, expected gates, expected fault line, expected shunt flag.
    logic [4:0] rows [4] = '{5'h01, 5'h09, 5'h15, 5'h1E};
    gdfs_supervisor #(.RETRY_CYCLES(50), .WAKE_CYCLES(30), .SLEEP_CYCLES(40),
        .RST_WIN_CYCLES(10)) gdfs_supervisor_inst (.ref_clk, .reset, .psel(req.psel),
        .penable(req.penable), .pwrite(req.pwrite), .paddr(req.paddr), .pwdata(req.pwdata),
        .prdata, .pready, .pslverr, .enable, .supply_undervoltage(uv),
        .shunt_sense_input(shunt), .vds_over(vds), .gate_cmd(gc), .gate_at_level(gl),
        .temp_warn(tw), .temp_shutdown(ts), .fault_out_n, .gates_enable,
        .charge_pump_en(cp_en), .regulators_en(reg_en), .serial_en(ser_en),
        .shunt_threshold_sel());
    gdfs_ctrl_model #(.WAKE(40)) gdfs_ctrl_model_inst (.ref_clk, .go, .pulse, .enable, .ready);
    initial forever #25 ref_clk = ~ref_clk;
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            errors++;
            $display("[ERR] %0t got %0h want %0h", $time, got, exp);
        end
    endtask
    task automatic tk(input int n);
        repeat (n) @(posedge ref_clk);
    endtask
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        @(posedge ref_clk);
        req <= '{1'b1, 1'b0, w, a, d};
        @(posedge ref_clk);
        req.penable <= 1'b1;
        do @(posedge ref_clk); while (pready !== 1'b1);
        q = prdata;
        serr = pslverr;
        req <= '0;
    endtask
    task automatic up();
        while (ready !== 1'b1) tk(1);
    endtask
    task automatic finish_test();
        $display("errors %0d tests_run %0d", errors, tests_run);
        if (errors == 0 && tests_run > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    always @(posedge ref_clk) begin
        cyc++;
        if (cyc == 10000) begin
            errors++;
            finish_test();
        end
    end
    initial begin
        tk(8);
        chk({fault_out_n, gates_enable}, 2'h2);
        reset <= 1'b0;
        go <= 1'b1;
        tk(4);
        chk(fault_out_n, 0);
        up();
        chk({fault_out_n, gates_enable}, 2'h3);
        apb(0, 8'h10, 0);
        chk(serr, 1);
        foreach (rows[i]) begin
            apb(1, CF, {26'h0, 4'hD, rows[i][4:3]});
            shunt <= 1'b1;
            tk(100);
            chk({gates_enable, fault_out_n}, rows[i][2:1]);
            apb(0, ST, 0);
            chk(q[2], rows[i][0]);
            shunt <= 1'b0;
            apb(1, CT, 1);
            tk(60);
            chk({gates_enable, fault_out_n}, 2'h3);
        end
        apb(1, CF, 32'h36);
        vds <= 6'h01;
        tk(5);
        chk({fault_out_n, gates_enable}, 2'h1);
        apb(1, CT, 1);
        tk(5);
        chk(fault_out_n, 0);
        vds <= 6'h00;
        tk(5);
        chk(fault_out_n, 0);
        apb(1, CT, 1);
        tk(5);
        chk(fault_out_n, 1);
        apb(1, CF, 32'h37);
        vds <= 6'h02;
        tk(5);
        chk(fault_out_n, 1);
        vds <= 6'h00;
        apb(1, CF, 32'h34);
        apb(1, CT, 32'h8);
        shunt <= 1'b1;
        tk(100);
        chk({fault_out_n, gates_enable}, 2'h3);
        vds <= 6'h04;
        tk(5);
        chk(fault_out_n, 0);
        shunt <= 1'b0;
        vds <= 6'h00;
        gc <= 6'h01;
        gl <= 6'h00;
        apb(1, CT, 1);
        tk(100);
        chk({fault_out_n, gates_enable}, 2'h0);
        gl <= 6'h01;
        apb(1, CT, 32'h6);
        pulse <= 1'b1;
        tk(1);
        pulse <= 1'b0;
        tk(2);
        up();
        chk({fault_out_n, gates_enable}, 2'h3);
        apb(0, CT, 0);
        chk(q, 32'h6);
        gc <= 6'h03;
        tw <= 1'b1;
        tk(100);
        chk({fault_out_n, gates_enable}, 2'h1);
        gl <= 6'h03;
        tw <= 1'b0;
        tk(5);
        chk(fault_out_n, 1);
        ts <= 1'b1;
        tk(5);
        chk({fault_out_n, gates_enable, cp_en}, 3'h0);
        ts <= 1'b0;
        tk(5);
        chk(fault_out_n, 1);
        apb(0, ST, 0);
        chk(q[5], 1);
        apb(1, CF, 32'h36);
        go <= 1'b0;
        tk(60);
        chk({reg_en, ser_en, cp_en}, 3'h0);
        apb(0, CF, 0);
        chk(serr, 1);
        go <= 1'b1;
        up();
        apb(0, CF, 0);
        chk(q, 32'h34);
        apb(1, CF, 32'h36);
        uv <= 1'b1;
        tk(5);
        chk({ser_en, cp_en, fault_out_n}, 3'h0);
        uv <= 1'b0;
        tk(5);
        apb(0, CF, 0);
        chk(q, 32'h34);
        finish_test();
    end
endmodule // tb
